/* rtl/apia_agen.sv */
// Top of the auxiliary-pointer indirect data-address generator.
// Assumes all request inputs come from CPU logic on clk; one operand per cycle.
`timescale 1ns/1ps
`include "apia_params.svh"

// Operation
// - Single-word pre-decrement: pointer minus one, then address
// - Long pre-decrement: pointer minus two, then address
// - Long second address: even plus one, odd minus
// - Legacy off: address, then add first temp
// - Legacy on: pointer zero replaces first temp
// - Subtract-offset: address, then subtract offset
// - Indexed: pointer plus offset, pointer unchanged
// - Bit-reversed add with reverse carry after address
// - Bit-reversed subtract with reverse borrow after address
// - Bit-reversed: base added, update not confined
// - Add second temp after address, legacy ignored
// - Subtract second temp after address
// - Address is high part above based low
module apia_agen
    import apia_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire apia_mode_t req_mode,
    input wire logic [`APIA_SEL_W-1:0] req_sel,
    input wire logic req_long,
    input wire logic [`APIA_LOW_W-1:0] first_temp_offset,
    input wire logic [`APIA_LOW_W-1:0] second_temp_offset,
    input wire logic [`APIA_LOW_W-1:0] buffer_start_base,
    input wire logic [`APIA_NUM_PTR-1:0] status_word_two,
    input wire logic legacy_compat_mode,
    input wire logic ptr_wr_en,
    input wire logic [`APIA_SEL_W-1:0] ptr_wr_sel,
    input wire logic [`APIA_EXT_W-1:0] ptr_wr_data,
    input wire logic [`APIA_SEL_W-1:0] rd_sel,
    output logic addr_valid,
    output logic [`APIA_EXT_W-1:0] addr_first,
    output logic [`APIA_EXT_W-1:0] addr_second,
    output logic addr_long,
    output logic [`APIA_EXT_W-1:0] extended_aux_pointer
);

    // ==========================================================
    // State
    typedef struct packed {
        logic valid;
        logic [`APIA_EXT_W-1:0] first;
        logic [`APIA_EXT_W-1:0] second;
        logic long_acc;
        logic [`APIA_EXT_W-1:0] rd_ptr;
    } apia_top_t;

    apia_top_t st;
    apia_top_t next_st;

    logic [`APIA_NUM_PTR-1:0][`APIA_LOW_W-1:0] low_all;
    logic [`APIA_NUM_PTR-1:0][`APIA_HIGH_W-1:0] high_all;
    logic [`APIA_LOW_W-1:0] cur_low;
    logic [`APIA_HIGH_W-1:0] cur_high;
    logic [`APIA_LOW_W-1:0] sel_offset;
    logic [`APIA_LOW_W-1:0] addr_low;
    logic [`APIA_LOW_W-1:0] next_low;
    logic update;
    logic circular;
    logic [`APIA_LOW_W-1:0] circ_sum;
    logic [`APIA_EXT_W-1:0] first_ext;

    // ==========================================================
    // Operand selection
    assign cur_low = low_all[req_sel];
    assign cur_high = high_all[req_sel];
    assign circular = status_word_two[req_sel];
    // Pointer zero read live, so a pending load of it is seen one cycle later
    assign sel_offset = legacy_compat_mode ? low_all[0] : first_temp_offset;
    assign circ_sum = cur_low + buffer_start_base;

    apia_addr_form u_form (
        .mode(req_mode),
        .long_acc(req_long),
        .cur_low(cur_low),
        .sel_offset(sel_offset),
        .second_temp_offset(second_temp_offset),
        .buffer_start_base(buffer_start_base),
        .circular(circular),
        .addr_low(addr_low),
        .next_low(next_low),
        .update(update)
    );

    apia_ptr_file u_ptrs (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(ptr_wr_en),
        .wr_sel(ptr_wr_sel),
        .wr_data(ptr_wr_data),
        .upd_en(req_valid && update),
        .upd_sel(req_sel),
        .upd_low(next_low),
        .low_all(low_all),
        .high_all(high_all)
    );

    assign first_ext = {cur_high, addr_low};

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.valid = req_valid;
        next_st.rd_ptr = {high_all[rd_sel], low_all[rd_sel]};
        if (req_valid) begin
            next_st.first = first_ext;
            next_st.long_acc = req_long;
            // Partner kept even on single-word access; addr_long says if it counts
            next_st.second = apia_pair(first_ext);
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.valid <= 1'b0;
            st.first <= `APIA_EXT_RST;
            st.second <= `APIA_EXT_RST;
            st.long_acc <= 1'b0;
            st.rd_ptr <= `APIA_EXT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign addr_valid = st.valid;
    assign addr_first = st.first;
    assign addr_second = st.second;
    assign addr_long = st.long_acc;
    assign extended_aux_pointer = st.rd_ptr;

    // ==========================================================
    // Check helpers
    // Reference terms built apart from the datapath
    logic [`APIA_LOW_W-1:0] chk_base;
    logic chk_same_wr;

    assign chk_base = circular ? buffer_start_base : `APIA_ZERO_LOW;
    assign chk_same_wr = ptr_wr_en && (ptr_wr_sel == req_sel);

    // Later checks take this clock and reset
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Checks
    a_predec_one: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_PREDEC && !req_long)
        |=> (low_all[$past(req_sel)] == $past(cur_low) - `APIA_STEP_ONE)
            && (addr_first[`APIA_LOW_W-1:0] == low_all[$past(req_sel)] + $past(chk_base)))
        else $error("pre-decrement by one wrong");

    a_predec_two: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_PREDEC && req_long && !circular)
        |=> (low_all[$past(req_sel)] == $past(cur_low) - `APIA_STEP_TWO)
            && (addr_first[`APIA_LOW_W-1:0] == low_all[$past(req_sel)]))
        else $error("pre-decrement by two wrong");

    a_long_pair: assert property (@(posedge clk) disable iff (!arst_n)
        (addr_valid && addr_long)
        |-> (addr_first[0] ? (addr_second == addr_first - 23'h000001)
                           : (addr_second == addr_first + 23'h000001)))
        else $error("long-word partner address wrong");

    a_add_first: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_ADD_OFS && !legacy_compat_mode && !circular)
        |=> (addr_first == {$past(cur_high), $past(cur_low)})
            && (low_all[$past(req_sel)] == $past(cur_low) + $past(first_temp_offset)))
        else $error("add first temporary wrong");

    a_legacy_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_SUB_OFS && legacy_compat_mode && req_sel != 3'h0)
        |=> (low_all[$past(req_sel)] == $past(cur_low) - $past(low_all[0])))
        else $error("legacy offset not pointer zero");

    a_sub_ofs: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_SUB_OFS && !legacy_compat_mode)
        |=> (low_all[$past(req_sel)] == $past(cur_low) - $past(first_temp_offset)))
        else $error("subtract offset wrong");

    a_indexed_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_INDEXED && !circular && !(ptr_wr_en && ptr_wr_sel == req_sel))
        |=> (low_all[$past(req_sel)] == $past(cur_low))
            && (addr_first[`APIA_LOW_W-1:0] == $past(cur_low) + $past(sel_offset)))
        else $error("indexed operand wrong");

    a_bitrev_add: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_BR_ADD)
        |=> (low_all[$past(req_sel)] == apia_bitrev($past(cur_low), $past(sel_offset), 1'b0)))
        else $error("bit-reversed add wrong");

    a_bitrev_sub: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_BR_SUB)
        |=> (low_all[$past(req_sel)] == apia_bitrev($past(cur_low), $past(sel_offset), 1'b1)))
        else $error("bit-reversed subtract wrong");

    a_bitrev_circ: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && circular && (req_mode == APIA_BR_ADD || req_mode == APIA_BR_SUB))
        |=> (addr_first[`APIA_LOW_W-1:0] == $past(circ_sum)))
        else $error("bit-reversed circular base missing");

    a_add_t2: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_ADD_T2)
        |=> (low_all[$past(req_sel)] == $past(cur_low) + $past(second_temp_offset)))
        else $error("add second temporary wrong");

    a_sub_t2: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && req_mode == APIA_SUB_T2)
        |=> (low_all[$past(req_sel)] == $past(cur_low) - $past(second_temp_offset)))
        else $error("subtract second temporary wrong");

    a_linear_addr: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && !circular && req_mode == APIA_PLAIN)
        |=> addr_valid && (addr_first == {$past(cur_high), $past(cur_low)}))
        else $error("linear address wrong");

    a_high_keep: assert property (@(posedge clk) disable iff (!arst_n)
        (req_valid && !(ptr_wr_en && ptr_wr_sel == req_sel))
        |=> (high_all[$past(req_sel)] == $past(cur_high))
            && (addr_first[`APIA_EXT_W-1:`APIA_LOW_W] == $past(cur_high)))
        else $error("high part disturbed");

    // Outputs, readback and hold; these use the default clock and reset
    a_valid_follow: assert property (
        $past(arst_n)
        |-> (addr_valid == $past(req_valid)))
        else $error("valid timing wrong");

    a_long_follow: assert property (
        req_valid
        |=> (addr_long == $past(req_long)))
        else $error("long flag wrong");

    a_second_flip: assert property (
        addr_valid
        |-> (addr_second == {addr_first[`APIA_EXT_W-1:1], ~addr_first[0]}))
        else $error("partner address wrong");

    a_ptr_readback: assert property (
        $past(arst_n)
        |-> (extended_aux_pointer == $past({high_all[rd_sel], low_all[rd_sel]})))
        else $error("pointer readback wrong");

    a_add_circ: assert property (
        req_valid && circular
            && req_mode == APIA_ADD_OFS
        |=> (addr_first == {$past(cur_high), $past(cur_low + buffer_start_base)}))
        else $error("circular base missing");

    a_predec_base: assert property (
        req_valid && req_mode == APIA_PREDEC && circular && !req_long
        |=> (addr_first[`APIA_LOW_W-1:0] == $past(cur_low) - `APIA_STEP_ONE + $past(buffer_start_base)))
        else $error("circular pre-decrement address wrong");

    a_legacy_index: assert property (
        req_valid && req_mode == APIA_INDEXED
            && legacy_compat_mode && !circular
        |=> (addr_first[`APIA_LOW_W-1:0] == $past(cur_low) + $past(low_all[0])))
        else $error("legacy indexed offset wrong");

    a_legacy_add: assert property (
        req_valid && req_mode == APIA_ADD_OFS && legacy_compat_mode
        |=> (low_all[$past(req_sel)] == $past(cur_low) + $past(low_all[0])))
        else $error("legacy add offset wrong");

    a_plain_keep: assert property (
        req_valid && !chk_same_wr
            && (req_mode == APIA_PLAIN || req_mode == APIA_INDEXED)
        |=> (low_all[$past(req_sel)] == $past(cur_low)))
        else $error("pointer moved without modify");

    a_load_high: assert property (
        ptr_wr_en
        |=> (high_all[$past(ptr_wr_sel)] == $past(ptr_wr_data[`APIA_EXT_W-1:`APIA_LOW_W])))
        else $error("high part not loaded");

    a_idle_hold: assert property (
        !req_valid && !ptr_wr_en
        |=> (low_all == $past(low_all)))
        else $error("pointer moved while idle");

    a_t2_legacy: assert property (
        req_valid && req_mode == APIA_ADD_T2 && legacy_compat_mode
        |=> (addr_first == {$past(cur_high), $past(cur_low) + $past(chk_base)}))
        else $error("second temporary address wrong");

    a_sub_base: assert property (
        req_valid && req_mode == APIA_SUB_OFS
        |=> (addr_first[`APIA_LOW_W-1:0] == $past(cur_low) + $past(chk_base)))
        else $error("subtract address wrong");

endmodule // apia_agen

/* inc/apia_params.svh */
// Constants of the auxiliary-pointer indirect address generator.
// Assumes one includer per compilation unit scope; guarded anyway.
`ifndef APIA_PARAMS_SVH
`define APIA_PARAMS_SVH

// ==========================================================
// Widths
`define APIA_LOW_W 16
`define APIA_HIGH_W 7
`define APIA_EXT_W 23
`define APIA_NUM_PTR 8
`define APIA_SEL_W 3
`define APIA_MODE_W 4

// ==========================================================
// Reset values and steps
`define APIA_LOW_RST 16'h0000
`define APIA_HIGH_RST 7'h00
`define APIA_EXT_RST 23'h000000
`define APIA_STEP_ONE 16'h0001
`define APIA_STEP_TWO 16'h0002
`define APIA_ZERO_LOW 16'h0000

`endif

/* inc/apia_pkg.sv */
// Types and shared arithmetic of the auxiliary-pointer address generator.
// Assumes apia_params.svh is on the include path.
`include "apia_params.svh"

package apia_pkg;

    // ==========================================================
    // Operand modes
    typedef enum logic [`APIA_MODE_W-1:0] {
        APIA_PLAIN   = 4'h0,
        APIA_PREDEC  = 4'h1,
        APIA_ADD_OFS = 4'h2,
        APIA_SUB_OFS = 4'h3,
        APIA_INDEXED = 4'h4,
        APIA_BR_ADD  = 4'h5,
        APIA_BR_SUB  = 4'h6,
        APIA_ADD_T2  = 4'h7,
        APIA_SUB_T2  = 4'h8
    } apia_mode_t;

    typedef logic [`APIA_LOW_W-1:0] apia_low_t;
    typedef logic [`APIA_EXT_W-1:0] apia_ext_t;

    // ==========================================================
    // Arithmetic
    function automatic apia_low_t apia_rev(input apia_low_t v);
        apia_low_t r;
        r = v;
        for (int i = 0; i < `APIA_LOW_W; i++) begin
            r[i] = v[`APIA_LOW_W-1-i];
        end
        return r;
    endfunction

    // Carries run from the top bit downward
    function automatic apia_low_t apia_bitrev(input apia_low_t a, input apia_low_t b, input logic sub);
        apia_low_t s;
        s = sub ? apia_rev(a) - apia_rev(b) : apia_rev(a) + apia_rev(b);
        return apia_rev(s);
    endfunction

    // Long-word partner: even goes up, odd goes down; never carries into the high part
    function automatic apia_ext_t apia_pair(input apia_ext_t a);
        apia_ext_t p;
        p = a;
        p[0] = ~a[0];
        return p;
    endfunction

endpackage

/* rtl/apia_ptr_file.sv */
// Eight extended auxiliary pointers with a load port and an update port.
// Assumes both ports come from logic on the same clock.
`timescale 1ns/1ps
`include "apia_params.svh"

module apia_ptr_file
    import apia_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [`APIA_SEL_W-1:0] wr_sel,
    input wire logic [`APIA_EXT_W-1:0] wr_data,
    input wire logic upd_en,
    input wire logic [`APIA_SEL_W-1:0] upd_sel,
    input wire logic [`APIA_LOW_W-1:0] upd_low,
    output logic [`APIA_NUM_PTR-1:0][`APIA_LOW_W-1:0] low_all,
    output logic [`APIA_NUM_PTR-1:0][`APIA_HIGH_W-1:0] high_all
);

    typedef struct packed {
        logic [`APIA_NUM_PTR-1:0][`APIA_LOW_W-1:0] low;
        logic [`APIA_NUM_PTR-1:0][`APIA_HIGH_W-1:0] high;
    } apia_pf_t;

    apia_pf_t st;
    apia_pf_t next_st;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.low[wr_sel] = wr_data[`APIA_LOW_W-1:0];
            next_st.high[wr_sel] = wr_data[`APIA_EXT_W-1:`APIA_LOW_W];
        end
        // Update wins over a load of the same pointer; the high part is never touched
        if (upd_en) begin
            next_st.low[upd_sel] = upd_low;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.low <= {`APIA_NUM_PTR{`APIA_LOW_RST}};
            st.high <= {`APIA_NUM_PTR{`APIA_HIGH_RST}};
        end else begin
            st <= next_st;
        end
    end

    assign low_all = st.low;
    assign high_all = st.high;

endmodule // apia_ptr_file

/* rtl/apia_addr_form.sv */
// Combinational address and pointer-update forming for one operand.
// Assumes the offset for the temporary-or-pointer-zero modes is already chosen.
`timescale 1ns/1ps
`include "apia_params.svh"

module apia_addr_form
    import apia_pkg::*;
(
    input wire apia_mode_t mode,
    input wire logic long_acc,
    input wire logic [`APIA_LOW_W-1:0] cur_low,
    input wire logic [`APIA_LOW_W-1:0] sel_offset,
    input wire logic [`APIA_LOW_W-1:0] second_temp_offset,
    input wire logic [`APIA_LOW_W-1:0] buffer_start_base,
    input wire logic circular,
    output logic [`APIA_LOW_W-1:0] addr_low,
    output logic [`APIA_LOW_W-1:0] next_low,
    output logic update
);

    logic [`APIA_LOW_W-1:0] eff;
    logic [`APIA_LOW_W-1:0] base;

    // ==========================================================
    // Mode decode
    always_comb begin
        eff = cur_low;
        next_low = cur_low;
        update = 1'b0;
        base = circular ? buffer_start_base : `APIA_ZERO_LOW;
        case (mode)
            APIA_PREDEC: begin
                next_low = cur_low - (long_acc ? `APIA_STEP_TWO : `APIA_STEP_ONE);
                eff = next_low;
                update = 1'b1;
            end
            APIA_ADD_OFS: begin
                next_low = cur_low + sel_offset;
                update = 1'b1;
            end
            APIA_SUB_OFS: begin
                next_low = cur_low - sel_offset;
                update = 1'b1;
            end
            APIA_INDEXED: begin
                eff = cur_low + sel_offset;
            end
            // Bit-reversed updates ignore the buffer bounds by design
            APIA_BR_ADD: begin
                next_low = apia_bitrev(cur_low, sel_offset, 1'b0);
                update = 1'b1;
            end
            APIA_BR_SUB: begin
                next_low = apia_bitrev(cur_low, sel_offset, 1'b1);
                update = 1'b1;
            end
            APIA_ADD_T2: begin
                next_low = cur_low + second_temp_offset;
                update = 1'b1;
            end
            APIA_SUB_T2: begin
                next_low = cur_low - second_temp_offset;
                update = 1'b1;
            end
            default: begin
                eff = cur_low;
            end
        endcase
        // Wraps in the low width, so the base never reaches the high part
        addr_low = eff + base;
    end

endmodule // apia_addr_form

/* verification/apia_mem_model.sv */
// Passive model of the data-memory address bus fed by the address generator.
// Assumes addresses arrive registered on clk with addr_valid as a one-cycle pulse.
`timescale 1ns/1ps

module apia_mem_model
    import apia_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic addr_valid,
    input wire apia_ext_t addr_first,
    input wire apia_ext_t addr_second,
    input wire logic addr_long,
    output logic [15:0] word_count
);
    // ==========================================================
    // Word counter
    // Counts words fetched so the bench can tie traffic to requests
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_count <= 16'h0000;
        end else if (addr_valid) begin
            // A long access whose second word is not the partner fetches one word only
            word_count <= word_count + ((addr_long && (addr_second == {addr_first[22:1], ~addr_first[0]}))
                ? 16'h0002 : 16'h0001);
        end
    end
endmodule // apia_mem_model

/* verification/aux_pointer_indirect_agen_tb_top.sv */
// Self-checking bench for the auxiliary-pointer indirect address generator.
// Assumes the package and apia_params.svh are compiled and on the include path.
`timescale 1ns/1ps
`include "apia_params.svh"

module aux_pointer_indirect_agen_tb_top
    import apia_pkg::*;
;
    // ==========================================================
    // Signals
    typedef struct {
        apia_mode_t mode;
        logic [`APIA_SEL_W-1:0] sel;
        logic [2:0] f;
        apia_ext_t ptr;
        apia_low_t t0;
        apia_low_t t1;
        apia_low_t base;
        apia_ext_t ea;
        apia_ext_t ep;
    } apia_row_t;
    logic clk = 1'h0;
    logic arst_n, req_valid, req_long, legacy_compat_mode, ptr_wr_en;
    apia_mode_t req_mode;
    logic [`APIA_SEL_W-1:0] req_sel, ptr_wr_sel, rd_sel;
    apia_low_t first_temp_offset, second_temp_offset, buffer_start_base;
    logic [7:0] status_word_two;
    apia_ext_t ptr_wr_data, addr_first, addr_second, extended_aux_pointer;
    logic addr_valid, addr_long;
    logic [15:0] word_count;
    int num_errors = 0;
    int comparisons = 0;
    int exp_words = 0;
    apia_row_t rows [18];

    always #2 clk = ~clk;

    apia_agen u_dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_mode(req_mode),
        .req_sel(req_sel), .req_long(req_long), .first_temp_offset(first_temp_offset),
        .second_temp_offset(second_temp_offset), .buffer_start_base(buffer_start_base),
        .status_word_two(status_word_two), .legacy_compat_mode(legacy_compat_mode),
        .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel), .ptr_wr_data(ptr_wr_data), .rd_sel(rd_sel),
        .addr_valid(addr_valid), .addr_first(addr_first), .addr_second(addr_second),
        .addr_long(addr_long), .extended_aux_pointer(extended_aux_pointer));

    apia_mem_model u_mem (.clk(clk), .arst_n(arst_n), .addr_valid(addr_valid), .addr_first(addr_first),
        .addr_second(addr_second), .addr_long(addr_long), .word_count(word_count));

    // ==========================================================
    // Tasks
    task automatic chk(input apia_ext_t got, input apia_ext_t exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_idle();
        chk({22'h0, addr_valid}, 23'h0, "valid idle");
        chk(addr_first, 23'h0, "first idle");
        chk(addr_second, 23'h0, "second idle");
        chk({22'h0, addr_long}, 23'h0, "long idle");
        chk(extended_aux_pointer, 23'h0, "pointer idle");
    endtask

    task automatic load(input logic [`APIA_SEL_W-1:0] s, input apia_ext_t d);
        @(posedge clk);
        ptr_wr_en <= 1'h1;
        ptr_wr_sel <= s;
        ptr_wr_data <= d;
        @(posedge clk);
        ptr_wr_en <= 1'h0;
    endtask

    // Holds the request one edge only; the next edge takes it
    task automatic run_op(input apia_row_t r);
        @(posedge clk);
        req_valid <= 1'h1;
        req_mode <= r.mode;
        req_sel <= r.sel;
        req_long <= r.f[0];
        legacy_compat_mode <= r.f[1];
        status_word_two <= r.f[2] ? (8'h01 << r.sel) : 8'h00;
        first_temp_offset <= r.t0;
        second_temp_offset <= r.t1;
        buffer_start_base <= r.base;
        rd_sel <= r.sel;
        @(posedge clk);
        req_valid <= 1'h0;
        #1;
        exp_words += 1 + r.f[0];
        chk({22'h0, addr_valid}, 23'h1, "valid");
        chk(addr_first, r.ea, "first");
        chk(addr_second, r.ea[0] ? r.ea - 23'h1 : r.ea + 23'h1, "second");
        chk({22'h0, addr_long}, {22'h0, r.f[0]}, "long");
        @(posedge clk);
        #1;
        chk(extended_aux_pointer, r.ep, "pointer");
        chk({22'h0, addr_valid}, 23'h0, "valid drop");
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        arst_n = 1'h0;
        req_valid = 1'h0;
        req_mode = APIA_PLAIN;
        req_sel = 3'h0;
        req_long = 1'h0;
        legacy_compat_mode = 1'h0;
        first_temp_offset = 16'h0;
        second_temp_offset = 16'h0;
        buffer_start_base = 16'h0;
        status_word_two = 8'h0;
        ptr_wr_en = 1'h0;
        ptr_wr_sel = 3'h0;
        ptr_wr_data = 23'h0;
        rd_sel = 3'h0;
        // Flags are {circular, legacy, long}
        rows[0] = '{APIA_PREDEC, 3'h1, 3'h0, 23'h2a0010, 16'h0, 16'h0, 16'h0, 23'h2a000f, 23'h2a000f};
        rows[1] = '{APIA_PREDEC, 3'h2, 3'h1, 23'h010010, 16'h0, 16'h0, 16'h0, 23'h01000e, 23'h01000e};
        rows[2] = '{APIA_PREDEC, 3'h3, 3'h1, 23'h030001, 16'h0, 16'h0, 16'h0, 23'h03ffff, 23'h03ffff};
        rows[3] = '{APIA_ADD_OFS, 3'h3, 3'h0, 23'h10, 16'h3, 16'h0, 16'h100, 23'h10, 23'h13};
        rows[4] = '{APIA_ADD_OFS, 3'h3, 3'h2, 23'h10, 16'h3, 16'h0, 16'h0, 23'h10, 23'h15};
        rows[5] = '{APIA_SUB_OFS, 3'h4, 3'h0, 23'h050010, 16'h20, 16'h0, 16'h0, 23'h050010, 23'h05fff0};
        rows[6] = '{APIA_INDEXED, 3'h5, 3'h1, 23'h100, 16'h23, 16'h0, 16'h0, 23'h123, 23'h100};
        rows[7] = '{APIA_INDEXED, 3'h5, 3'h2, 23'h100, 16'h3, 16'h0, 16'h0, 23'h105, 23'h100};
        rows[8] = '{APIA_BR_ADD, 3'h6, 3'h0, 23'h8000, 16'h8000, 16'h0, 16'h0, 23'h8000, 23'h4000};
        rows[9] = '{APIA_BR_SUB, 3'h6, 3'h0, 23'h4000, 16'h8000, 16'h0, 16'h0, 23'h4000, 23'h8000};
        rows[10] = '{APIA_BR_ADD, 3'h7, 3'h4, 23'h4000, 16'h4000, 16'h0, 16'h1000, 23'h5000, 23'h2000};
        rows[11] = '{APIA_ADD_T2, 3'h1, 3'h2, 23'h40, 16'h3, 16'h7, 16'h0, 23'h40, 23'h47};
        rows[12] = '{APIA_SUB_T2, 3'h2, 3'h0, 23'h40, 16'h0, 16'h7, 16'h0, 23'h40, 23'h39};
        rows[13] = '{APIA_ADD_OFS, 3'h4, 3'h4, 23'h070010, 16'h1, 16'h0, 16'h100, 23'h070110, 23'h070011};
        rows[14] = '{apia_mode_t'(4'h9), 3'h1, 3'h0, 23'h44, 16'h5, 16'h5, 16'h0, 23'h44, 23'h44};
        rows[15] = '{APIA_PLAIN, 3'h2, 3'h1, 23'h012345, 16'h0, 16'h0, 16'h0, 23'h012345, 23'h012345};
        rows[16] = '{APIA_SUB_OFS, 3'h4, 3'h2, 23'h050010, 16'h20, 16'h0, 16'h0, 23'h050010, 23'h05000b};
        rows[17] = '{APIA_PREDEC, 3'h5, 3'h4, 23'h10, 16'h0, 16'h0, 16'h200, 23'h20f, 23'hf};
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        #1;
        chk_idle();
        $display("Reset test done");
        load(3'h0, 23'h000005);
        foreach (rows[i]) begin
            load(rows[i].sel, rows[i].ptr);
            run_op(rows[i]);
        end
        $display("Mode table done");
        // Back to back: the second request must see the first update
        load(3'h1, 23'h40);
        @(posedge clk);
        req_valid <= 1'h1;
        req_mode <= APIA_ADD_T2;
        req_sel <= 3'h1;
        req_long <= 1'h0;
        status_word_two <= 8'h00;
        second_temp_offset <= 16'h2;
        rd_sel <= 3'h1;
        @(posedge clk);
        #1;
        chk(addr_first, 23'h40, "first of pair");
        @(posedge clk);
        req_valid <= 1'h0;
        #1;
        chk({22'h0, addr_valid}, 23'h1, "valid of second");
        chk(addr_first, 23'h42, "second of pair");
        @(posedge clk);
        #1;
        chk(extended_aux_pointer, 23'h44, "pointer after pair");
        exp_words += 2;
        chk({7'h0, word_count}, apia_ext_t'(exp_words), "words fetched");
        $display("Back to back test done");
        // Reset in mid-run clears outputs and pointers
        @(posedge clk);
        arst_n <= 1'h0;
        @(posedge clk);
        #1;
        chk_idle();
        @(posedge clk);
        arst_n <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk_idle();
        $display("Mid-run reset test done");
        print_verdict();
    end
endmodule // aux_pointer_indirect_agen_tb_top
